// file: core/pdc_dram_ctrl.sv
`timescale 1ns/1ns
module pdc_dram_ctrl
  import pdc_pkg::*;
#(
  parameter int MW = MUX_W,
  parameter int WW = WAIT_W
)(
  input wire logic mclk,
  input wire logic arst_n,
  // Internal bus interface unit side
  input wire logic address_latch_enable,
  input wire logic [pdc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_burst,
  input wire logic [3:0] bus_byte_en,
  input wire logic external_wait,
  output pdc_pkg::pdc_hit_t access_class,
  output logic access_acknowledge_n,
  output logic read_buffer_enable_n,
  output logic busy,
  // Configuration
  input wire logic [3:0] dram_region,
  input wire logic [7:0] bank_density,
  input wire logic [3:0] bank_is_16bit,
  input wire logic [3:0] bank_base,
  input wire logic [1:0] pair_interleave,
  input wire logic xcvr_type,
  input wire logic big_endian,
  input wire logic burst_acknowledge_field,
  input wire logic [WW-1:0] wait_read_single,
  input wire logic [WW-1:0] wait_read_burst,
  input wire logic [WW-1:0] wait_write_single,
  input wire logic [WW-1:0] wait_write_burst,
  input wire logic [pdc_pkg::REFRESH_W-1:0] refresh_period,
  // DRAM pins
  output logic [MW-1:0] system_address_bus,
  output logic system_address_mux_active,
  output logic [3:0] row_strobe_n,
  output logic [3:0] column_strobe_n,
  output logic even_bank_write_enable_n,
  output logic odd_bank_write_enable_n,
  output logic even_bank_read_enable_n,
  output logic odd_bank_read_enable_n,
  output logic upper_half_active
);
  import pdc_pkg::*;

  typedef enum logic [3:0] {
    PDC_IDLE, PDC_PRECH, PDC_ROW, PDC_RCD, PDC_COL, PDC_NEXT,
    PDC_REF_CAS, PDC_REF_RAS, PDC_REF_END
  } pdc_state_t;

  pdc_state_t state;
  logic [ADDR_W-1:0] addr_q;
  logic write_q, burst_q;
  logic [3:0] be_q;
  logic [1:0] bank_q;
  logic [3:0] beats_left;
  logic [3:0] timer;
  logic [3:0] open_rows;
  logic [MW-1:0] open_page [NBANK];
  logic ws_start, ws_done;
  logic ref_req, ref_taken;
  logic [WW-1:0] ws_count;
  logic [1:0] sel_bank;
  logic page_hit;
  logic is_16;

  ////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic pdc_hit_t classify(input logic [ADDR_W-1:0] a,
                                        input logic [3:0] region);
    if (a[31:28] == REG_REGION)
      classify = PDC_HIT_REG;
    else if (a[31:28] == region)
      classify = PDC_HIT_DRAM;
    else
      classify = PDC_HIT_NONE;
  endfunction

  // Row bits depend on density and port width
  function automatic logic [MW-1:0] row_of(input logic [ADDR_W-1:0] a,
                                           input logic [1:0] dens,
                                           input logic w16,
                                           input logic ilv);
    logic [ADDR_W-1:0] s;
    s = w16 ? (a >> 1) : (ilv ? (a >> 3) : (a >> 2));
    case (dens)
      DENS_1M: row_of = {2'h0, s[19:10]};
      DENS_4M: row_of = {1'h0, s[21:11]};
      DENS_16M: row_of = s[23:12];
      default: row_of = {2'h0, s[19:10]};
    endcase
  endfunction

  function automatic logic [MW-1:0] col_of(input logic [ADDR_W-1:0] a,
                                           input logic [1:0] dens,
                                           input logic w16,
                                           input logic ilv);
    logic [ADDR_W-1:0] s;
    s = w16 ? (a >> 1) : (ilv ? (a >> 3) : (a >> 2));
    case (dens)
      DENS_1M: col_of = {2'h0, s[9:0]};
      DENS_4M: col_of = {1'h0, s[10:0]};
      DENS_16M: col_of = s[11:0];
      default: col_of = {2'h0, s[9:0]};
    endcase
  endfunction

  assign access_class = classify(bus_addr, dram_region);

  // Bank chosen from A27 (pair) and A26; interleaved pairs use A2 for even/odd
  always_comb
  begin
    sel_bank = bus_addr[27] ? 2'h2 : 2'h0;
    if (bus_addr[26] != bank_base[sel_bank])
      sel_bank = sel_bank;
    if (pair_interleave[sel_bank[1]])
      sel_bank[0] = bus_addr[2];
    else
      sel_bank[0] = bus_addr[26];
  end

  assign is_16 = bank_is_16bit[bank_q];
  assign page_hit = open_rows[bank_q] &&
    (open_page[bank_q] == row_of(addr_q, bank_density[2*bank_q +: 2],
                                 is_16, pair_interleave[bank_q[1]]));

  ////////////////////////////////////////////////////////////////////////
  // Wait-states and refresh

  always_comb
  begin
    case ({write_q, burst_q})
      2'b00: ws_count = wait_read_single;
      2'b01: ws_count = wait_read_burst;
      2'b10: ws_count = wait_write_single;
      default: ws_count = wait_write_burst;
    endcase
  end

  // External wait only honoured with burst acknowledge off
  pdc_wait_gen #(.W(WW)) u_wait (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(ws_start),
    .count(ws_count),
    .hold(external_wait && !burst_acknowledge_field),
    .done(ws_done)
  );

  pdc_refresh_timer #(.W(REFRESH_W)) u_refresh (
    .mclk(mclk),
    .arst_n(arst_n),
    .period(refresh_period),
    .taken(ref_taken),
    .request(ref_req)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control sequencer

  assign ref_taken = (state == PDC_IDLE) && ref_req;
  assign ws_start = (state == PDC_RCD && timer == '0) ||
                    (state == PDC_NEXT);
  assign busy = (state != PDC_IDLE);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= PDC_IDLE;
      addr_q <= '0;
      write_q <= 1'b0;
      burst_q <= 1'b0;
      be_q <= '0;
      bank_q <= '0;
      beats_left <= '0;
      timer <= '0;
      open_rows <= '0;
      row_strobe_n <= 4'hF;
      column_strobe_n <= 4'hF;
      access_acknowledge_n <= 1'b1;
      read_buffer_enable_n <= 1'b1;
      system_address_bus <= '0;
      system_address_mux_active <= 1'b0;
      upper_half_active <= 1'b0;
      for (int i = 0; i < NBANK; i++)
        open_page[i] <= '0;
    end
    else
    begin
      access_acknowledge_n <= 1'b1;
      read_buffer_enable_n <= 1'b1;
      if (timer != '0)
        timer <= timer - 1'b1;
      case (state)
        PDC_IDLE:
        begin
          column_strobe_n <= 4'hF;
          system_address_mux_active <= 1'b0;
          if (ref_req)
          begin
            row_strobe_n <= 4'hF;
            open_rows <= '0;
            timer <= PRECHARGE_CYCLES;
            state <= PDC_REF_CAS;
          end
          else if (address_latch_enable &&
                   classify(bus_addr, dram_region) == PDC_HIT_DRAM)
          begin
            addr_q <= bus_addr;
            write_q <= bus_write;
            burst_q <= bus_burst;
            be_q <= bus_byte_en;
            bank_q <= sel_bank;
            system_address_mux_active <= 1'b1;
            if (bank_is_16bit[sel_bank])
              beats_left <= bus_burst ? BEATS_W16_BURST : BEATS_W16_SINGLE;
            else
              beats_left <= bus_burst ? BEATS_W32_BURST : 4'h1;
            state <= PDC_PRECH;
          end
        end
        PDC_PRECH:
        begin
          if (page_hit)
          begin
            // Column address and write enable settle before the edge
            timer <= RAS_TO_CAS_CYCLES;
            state <= PDC_RCD;
          end
          else
          begin
            // Close every open row before opening another; an interleaved pair closes only this bank's row
            if (!pair_interleave[bank_q[1]])
            begin
              row_strobe_n <= 4'hF;
              open_rows <= '0;
            end
            else
            begin
              row_strobe_n[bank_q] <= 1'b1;
              open_rows[bank_q] <= 1'b0;
            end
            timer <= PRECHARGE_CYCLES;
            state <= PDC_ROW;
          end
        end
        PDC_ROW:
        begin
          system_address_bus <= row_of(addr_q, bank_density[2*bank_q +: 2],
                                       is_16, pair_interleave[bank_q[1]]);
          if (timer == '0)
          begin
            row_strobe_n[bank_q] <= 1'b0;
            open_rows[bank_q] <= 1'b1;
            open_page[bank_q] <= row_of(addr_q,
              bank_density[2*bank_q +: 2], is_16,
              pair_interleave[bank_q[1]]);
            timer <= RAS_TO_CAS_CYCLES;
            state <= PDC_RCD;
          end
        end
        PDC_RCD:
        begin
          system_address_bus <= col_of(addr_q, bank_density[2*bank_q +: 2],
                                       is_16, pair_interleave[bank_q[1]]);
          if (timer == '0)
          begin
            // Write enable already low here, ahead of the column edge
            if (is_16)
            begin
              upper_half_active <= big_endian;
              column_strobe_n <= big_endian ?
                {~(be_q[3] | be_q[2]), ~(be_q[3] | be_q[2]), 2'h3} :
                {2'h3, ~(be_q[1] | be_q[0]), ~(be_q[1] | be_q[0])};
            end
            else
            begin
              upper_half_active <= 1'b0;
              column_strobe_n <= ~be_q;
            end
            state <= PDC_COL;
          end
        end
        PDC_COL:
        begin
          read_buffer_enable_n <= write_q;
          if (ws_done)
          begin
            access_acknowledge_n <= 1'b0;
            column_strobe_n <= 4'hF;
            if (beats_left <= 4'h1)
              state <= PDC_IDLE;
            else
            begin
              beats_left <= beats_left - 1'b1;
              addr_q <= is_16 ? addr_q + 32'h2 : addr_q + 32'h4;
              state <= PDC_NEXT;
            end
          end
        end
        PDC_NEXT:
        begin
          // Page-mode beat: row stays open, new column only
          system_address_bus <= col_of(addr_q, bank_density[2*bank_q +: 2],
                                       is_16, pair_interleave[bank_q[1]]);
          column_strobe_n <= is_16 ?
            (big_endian ? 4'h3 : 4'hC) : 4'h0;
          state <= PDC_COL;
        end
        PDC_REF_CAS:
        begin
          if (timer == '0)
          begin
            column_strobe_n <= 4'h0;
            state <= PDC_REF_RAS;
          end
        end
        PDC_REF_RAS:
        begin
          row_strobe_n <= 4'h0;
          timer <= REFRESH_RAS_CYCLES;
          state <= PDC_REF_END;
        end
        PDC_REF_END:
        begin
          if (timer == '0)
          begin
            row_strobe_n <= 4'hF;
            column_strobe_n <= 4'hF;
            state <= PDC_IDLE;
          end
        end
        default: state <= PDC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write and transceiver enables

  logic data_phase;
  assign data_phase = (state == PDC_RCD) || (state == PDC_COL) ||
                      (state == PDC_NEXT);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      even_bank_write_enable_n <= 1'b1;
      odd_bank_write_enable_n <= 1'b1;
      even_bank_read_enable_n <= 1'b1;
      odd_bank_read_enable_n <= 1'b1;
    end
    else
    begin
      // Refresh never drives write enables
      even_bank_write_enable_n <= !(data_phase && write_q && !bank_q[0]);
      odd_bank_write_enable_n <= !(data_phase && write_q && bank_q[0]);
      if (xcvr_type == XCVR_EXCHANGER)
      begin
        even_bank_read_enable_n <= !(data_phase && !write_q);
        odd_bank_read_enable_n <= !(data_phase && !write_q && bank_q[0]);
      end
      else
      begin
        even_bank_read_enable_n <= !(data_phase && !bank_q[0]);
        odd_bank_read_enable_n <= !(data_phase && bank_q[0]);
      end
    end
  end
endmodule

// file: core/pdc_pkg.sv
// Functional notes
// - DRAM access muxes twelve address pins
// - Four active-low row strobes, one per bank
// - Column strobes per byte lane, endian halves
// - Even write enable writes bank 0/2
// - Odd write enable writes bank 1/3
// - Early write: enable before column strobes
// - Read enables gate bank-pair transceivers on reads
// - Exchanger mode: even read enable is path enable
// - Exchanger mode: odd read enable selects pair
// - Bidirectional mode: enables on reads and writes
// - 16-bit bank uses endian data half
// - Latch enable starts; cycle may be delayed
// - Wait input during column strobe adds wait-states, only with burst acknowledge off
// - Count programmed wait-states, then acknowledge datum
// - Waits separate for read/write, single/burst
// - Generate read buffer enable and acknowledge timing
// - Periodic column-before-row refresh
// - Decode register, DRAM area, or neither
// - Store row, page-mode on same block
// - Per-bank density and port width
// - Per-pair interleave option
// - One row strobe open when not interleaved
// - 16-bit block read is eight page reads
// - Close row on refresh or page miss
package pdc_pkg;
  localparam int ADDR_W = 32;
  localparam int MUX_W = 12;
  localparam int NBANK = 4;
  localparam int WAIT_W = 4;
  localparam int REFRESH_W = 12;
  localparam logic [11:0] REFRESH_DEFAULT = 12'h186;
  localparam logic [3:0] PRECHARGE_CYCLES = 4'h2;
  localparam logic [3:0] RAS_TO_CAS_CYCLES = 4'h1;
  localparam logic [3:0] REFRESH_RAS_CYCLES = 4'h3;
  localparam logic [3:0] REG_REGION = 4'hF;
  localparam logic [1:0] DENS_1M = 2'h0;
  localparam logic [1:0] DENS_4M = 2'h1;
  localparam logic [1:0] DENS_16M = 2'h2;
  localparam logic XCVR_EXCHANGER = 1'h0;
  localparam logic XCVR_BIDIR = 1'h1;
  localparam logic [3:0] BEATS_W32_BURST = 4'h4;
  localparam logic [3:0] BEATS_W16_BURST = 4'h8;
  localparam logic [3:0] BEATS_W16_SINGLE = 4'h2;
  typedef enum logic [1:0] {PDC_HIT_NONE, PDC_HIT_REG, PDC_HIT_DRAM}
    pdc_hit_t;
endpackage

// file: core/pdc_wait_gen.sv
`timescale 1ns/1ns
module pdc_wait_gen
  import pdc_pkg::*;
#(
  parameter int W = WAIT_W
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [W-1:0] count,
  input wire logic hold,
  output logic done
);
  logic [W-1:0] left;
  logic busy;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left <= '0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      left <= count;
      busy <= 1'b1;
    end
    else if (busy && !hold)
    begin
      if (left == '0)
        busy <= 1'b0;
      else
        left <= left - 1'b1;
    end
  end

  assign done = busy && !hold && (left == '0);
endmodule

// file: core/pdc_refresh_timer.sv
`timescale 1ns/1ns
module pdc_refresh_timer
  import pdc_pkg::*;
#(
  parameter int W = REFRESH_W
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] period,
  input wire logic taken,
  output logic request
);
  logic [W-1:0] tick;

  // Request stays pending until serviced, so none is lost
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick <= '0;
      request <= 1'b0;
    end
    else
    begin
      if (tick >= period)
        tick <= '0;
      else
        tick <= tick + 1'b1;
      if (tick >= period && period != '0)
        request <= 1'b1;
      else if (taken)
        request <= 1'b0;
    end
  end
endmodule

// file: sim/pdc_dram_ctrl_asserts.sv
`timescale 1ns/1ns
module pdc_dram_ctrl_asserts
  import pdc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic address_latch_enable,
  input wire logic [pdc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [1:0] pair_interleave,
  input wire logic [3:0] bank_is_16bit,
  input wire logic big_endian,
  input wire pdc_pkg::pdc_hit_t access_class,
  input wire logic system_address_mux_active,
  input wire logic access_acknowledge_n,
  input wire logic read_buffer_enable_n,
  input wire logic busy,
  input wire logic [3:0] row_strobe_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic even_bank_write_enable_n,
  input wire logic odd_bank_write_enable_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic wr_n;
  assign wr_n = even_bank_write_enable_n & odd_bank_write_enable_n;
  sequence taken_s;
    address_latch_enable && access_class == PDC_HIT_DRAM && !busy;
  endsequence
  sequence cas_only_s;
    column_strobe_n != 4'hF && row_strobe_n == 4'hF;
  endsequence
  sequence cas_edge_s;
    $past(column_strobe_n) == 4'hF && column_strobe_n != 4'hF;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_ACK_PULSE:
  assert property (!access_acknowledge_n |=> access_acknowledge_n)
    else $error("acknowledge held longer than one cycle");
  AST_MUX_ON_ACK:
  assert property (!access_acknowledge_n |-> system_address_mux_active)
    else $error("address mux idle at acknowledge");
  AST_TAKEN_BUSY:
  assert property (taken_s |=> busy)
    else $error("accepted access did not start");
  AST_TAKEN_ACK:
  assert property (taken_s |-> ##[3:120] !access_acknowledge_n)
    else $error("accepted access never acknowledged");
  AST_DECODE_REG:
  assert property (bus_addr[31:28] == REG_REGION |->
                   access_class == PDC_HIT_REG)
    else $error("register region not decoded");
  AST_WE_EXCL:
  assert property (even_bank_write_enable_n || odd_bank_write_enable_n)
    else $error("both write enables low");
  AST_EARLY_WRITE:
  assert property (cas_edge_s and !wr_n |-> $past(wr_n) == 1'b0)
    else $error("write enable not ahead of column strobe");
  AST_CBR:
  assert property (cas_only_s |-> ##[1:6] row_strobe_n != 4'hF)
    else $error("column-only strobe not followed by row strobe");
  AST_ONE_ROW:
  assert property (pair_interleave == 2'h0 && !read_buffer_enable_n |->
                   $onehot(~row_strobe_n))
    else $error("row strobes not one-hot while reading");
  AST_READ_NO_WE:
  assert property (!read_buffer_enable_n |-> wr_n)
    else $error("write enable during read column phase");
  AST_LANE_BE:
  assert property (bank_is_16bit == 4'hF && big_endian && !wr_n |->
                   column_strobe_n[1:0] == 2'h3)
    else $error("low lanes strobed on big-endian 16-bit write");
endmodule

// file: sim/pdc_dram_model.sv
`timescale 1ns/1ns
module pdc_dram_model
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] row_strobe_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic odd_bank_write_enable_n,
  input wire logic even_bank_read_enable_n,
  input wire logic odd_bank_read_enable_n,
  input wire logic burst_acknowledge_field,
  input wire logic stretch,
  output logic external_wait,
  output int refresh_count,
  output int odd_write_count,
  output int even_read_count,
  output int odd_read_count
);
  logic [3:0] cas_q;
  logic er_q;
  logic or_q;
  int hold;
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      cas_q <= 4'hF;
      er_q <= 1'b1;
      or_q <= 1'b1;
      hold <= 0;
      external_wait <= 1'b0;
      refresh_count <= 0;
      odd_write_count <= 0;
      even_read_count <= 0;
      odd_read_count <= 0;
    end
    else
    begin
      cas_q <= column_strobe_n;
      er_q <= even_bank_read_enable_n;
      or_q <= odd_bank_read_enable_n;
      hold <= (column_strobe_n != 4'hF) ? hold + 1 : 0;
      // Two cycles only, else the column phase never ends
      external_wait <= stretch && !burst_acknowledge_field &&
                       column_strobe_n != 4'hF && hold < 2;
      if (cas_q == 4'hF && column_strobe_n != 4'hF)
      begin
        if (row_strobe_n == 4'hF)
          refresh_count <= refresh_count + 1;
        else if (!odd_bank_write_enable_n)
          odd_write_count <= odd_write_count + 1;
      end
      if (er_q && !even_bank_read_enable_n)
        even_read_count <= even_read_count + 1;
      if (or_q && !odd_bank_read_enable_n)
        odd_read_count <= odd_read_count + 1;
    end
endmodule

// file: sim/tb_pdc_dram_ctrl.sv
`timescale 1ns/1ns
module tb_pdc_dram_ctrl;
  import pdc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic address_latch_enable = 1'b0;
  logic bus_write = 1'b0;
  logic bus_burst = 1'b0;
  logic [ADDR_W-1:0] bus_addr = 32'h0;
  logic [3:0] bus_byte_en = 4'hF;
  logic [3:0] bank_is_16bit = 4'h0;
  logic [1:0] pair_interleave = 2'h0;
  logic xcvr_type = XCVR_EXCHANGER;
  logic big_endian = 1'b0;
  logic burst_acknowledge_field = 1'b0;
  logic stretch = 1'b0;
  logic [WAIT_W-1:0] wait_read_single = 4'h0;
  logic [WAIT_W-1:0] wait_read_burst = 4'h0;
  logic [WAIT_W-1:0] wait_write_single = 4'h5;
  logic [WAIT_W-1:0] wait_write_burst = 4'h1;
  logic [REFRESH_W-1:0] refresh_period = 12'h000;
  wire logic [3:0] dram_region = 4'h0;
  wire logic [3:0] bank_base = 4'h0;
  logic [7:0] bank_density = {4{DENS_1M}};
  pdc_hit_t access_class;
  logic access_acknowledge_n, read_buffer_enable_n, busy, external_wait;
  logic system_address_mux_active, upper_half_active;
  logic even_bank_write_enable_n, odd_bank_write_enable_n;
  logic even_bank_read_enable_n, odd_bank_read_enable_n;
  logic [MUX_W-1:0] system_address_bus;
  logic [3:0] row_strobe_n, column_strobe_n;
  int refresh_count, odd_write_count, even_read_count, odd_read_count;
  int mismatches = 0;
  int check_count = 0;
  logic [3:0] regs [3] = '{4'h0, 4'hF, 4'h5};
  pdc_hit_t hits [3] = '{PDC_HIT_DRAM, PDC_HIT_REG, PDC_HIT_NONE};
  pdc_dram_ctrl i_dut (.*);
  pdc_dram_model i_mem (.*);
  always #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Task waits for idle; returns beats seen and cycle of the last one
  task automatic access(input logic [31:0] a, input logic w, input logic b,
                        output int acks, output int lat);
    int n;
    acks = 0;
    lat = 0;
    @(posedge mclk);
    address_latch_enable <= 1'b1;
    bus_addr <= a;
    bus_write <= w;
    bus_burst <= b;
    @(posedge mclk);
    address_latch_enable <= 1'b0;
    for (n = 0; n < 300; n++)
    begin
      @(posedge mclk);
      #1;
      if (access_acknowledge_n === 1'b0)
      begin
        acks++;
        lat = n;
      end
      if (busy === 1'b0)
        break;
    end
    if (n == 300)
    begin
      mismatches++;
      $display("mismatch at %0t: access hung", $time);
      print_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int c, l0, l1, l2, l3, k;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    check({row_strobe_n, column_strobe_n} === 8'hFF, "strobes");
    check({even_bank_write_enable_n, odd_bank_write_enable_n,
           even_bank_read_enable_n, odd_bank_read_enable_n,
           access_acknowledge_n} === 5'h1F, "enables");
    foreach (regs[i])
    begin
      @(posedge mclk);
      bus_addr <= {regs[i], 28'h0000000};
      @(posedge mclk);
      #1;
      check(access_class === hits[i], "decode");
    end
    access(32'h0000_1000, 1'b0, 1'b0, c, l0);
    check(c == 1, "single read beats");
    check(even_read_count > 0, "even read enable");
    access(32'h0000_2000, 1'b0, 1'b0, c, l0);
    @(posedge mclk);
    wait_read_single <= 4'h3;
    access(32'h0000_3000, 1'b0, 1'b0, c, l1);
    check(l1 - l0 == 3, "read wait-states");
    access(32'h0000_3004, 1'b0, 1'b0, c, l2);
    check(l2 < l1, "page hit faster");
    @(posedge mclk);
    bank_density <= {4{DENS_16M}};
    access(32'h0000_2000, 1'b0, 1'b0, c, l0);
    access(32'h0000_3000, 1'b0, 1'b0, c, l0);
    check(l0 < l1, "16M rows share a page");
    @(posedge mclk);
    bank_density <= {4{DENS_1M}};
    stretch <= 1'b1;
    access(32'h0000_4000, 1'b0, 1'b0, c, l3);
    check(l3 > l1, "external wait");
    @(posedge mclk);
    stretch <= 1'b0;
    access(32'h0000_5000, 1'b0, 1'b1, c, l0);
    check(c == 4, "32-bit burst beats");
    @(posedge mclk);
    bank_is_16bit <= 4'hF;
    big_endian <= 1'b1;
    access(32'h0000_6000, 1'b0, 1'b1, c, l0);
    check(c == 8, "16-bit burst beats");
    access(32'h0000_7000, 1'b1, 1'b0, c, l0);
    check(c == 2, "16-bit write beats");
    check(upper_half_active === 1'b1, "upper data half");
    @(posedge mclk);
    bank_is_16bit <= 4'h0;
    big_endian <= 1'b0;
    xcvr_type <= XCVR_BIDIR;
    k = odd_read_count;
    c = odd_write_count;
    access(32'h0400_1000, 1'b1, 1'b0, l1, l0);
    check(odd_write_count == c + 1, "odd bank write");
    check(odd_read_count > k, "odd enable on write");
    @(posedge mclk);
    xcvr_type <= XCVR_EXCHANGER;
    pair_interleave <= 2'h1;
    k = odd_read_count;
    access(32'h0000_1004, 1'b0, 1'b0, c, l0);
    check(odd_read_count > k, "interleaved odd select");
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    #1;
    check({row_strobe_n, column_strobe_n, odd_bank_read_enable_n} === 9'h1FF,
          "strobes after mid-run reset");
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    refresh_period <= 12'h020;
    k = refresh_count;
    repeat (200) @(posedge mclk);
    check(refresh_count > k, "refresh cycles");
    refresh_period <= 12'h000;
    repeat (20) @(posedge mclk);
    print_verdict();
  end
endmodule
bind pdc_dram_ctrl pdc_dram_ctrl_asserts i_chk (.*);
